/* i2c_target_pkg.sv */
// shared constants and types of the i2c target register block
package i2c_target_pkg;

  // ********************
  // bus geometry
  // ********************
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ********************
  // register indices, byte address is index times four
  // ********************
  localparam logic [7:0] IDX_OWN  = 8'hE3;
  localparam logic [7:0] IDX_DBUF = 8'hE4;
  localparam logic [7:0] IDX_CFG  = 8'hE5;
  localparam logic [7:0] IDX_STAT = 8'hE8;
  localparam logic [7:0] IDX_HOLD = 8'hE9;
  localparam logic [7:0] IDX_FILT = 8'hF2;

  // ********************
  // reset values and writable masks
  // ********************
  localparam logic [7:0] OWN_RST   = 8'h00;
  localparam logic [7:0] DBUF_RST  = 8'h00;
  localparam logic [7:0] CFG_RST   = 8'h10;
  localparam logic [7:0] STAT_RST  = 8'h44;
  localparam logic [7:0] HOLD_RST  = 8'h00;
  localparam logic [7:0] FILT_RST  = 8'h40;
  localparam logic [7:0] CFG_MASK  = 8'h3F;
  localparam logic [7:0] FILT_MASK = 8'h7F;

  // ********************
  // field positions
  // ********************
  localparam int unsigned CFG_SRST = 5;
  localparam int unsigned CFG_RDS  = 4;
  localparam int unsigned CFG_WRS  = 3;
  localparam int unsigned CFG_REL  = 2;
  localparam int unsigned CFG_SLEW = 1;
  localparam int unsigned CFG_EN   = 0;
  localparam int unsigned ST_START = 7;
  localparam int unsigned ST_STOP  = 6;
  localparam int unsigned ST_DIR   = 5;
  localparam int unsigned ST_AD    = 4;
  localparam int unsigned ST_BF    = 3;
  localparam int unsigned ST_ACK   = 2;
  localparam int unsigned ST_WCOL  = 1;
  localparam int unsigned ST_ROVF  = 0;

  // count of scl falls that completes a byte, minus one
  localparam logic [3:0] BIT_LAST = 4'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h3, S_WDATA = 3'h2,
    S_WACK = 3'h6, S_RDATA = 3'h7, S_RACK = 3'h5
  } state_t;

  typedef struct packed {
    logic       fire;
    logic [7:0] idx;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic       fire;
    logic [7:0] idx;
  } reg_rd_t;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    reg_hit = (addr[ADDR_W-1:10] == '0) && (i == IDX_OWN || i == IDX_DBUF ||
              i == IDX_CFG || i == IDX_STAT || i == IDX_HOLD || i == IDX_FILT);
  endfunction : reg_hit

endpackage : i2c_target_pkg

/* pin_sync.sv */
// two-stage synchroniser for the bus pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t q, d;

  // first stage feeds only the second
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  // idle bus lines rest high
  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '1;
    else          q <= d;
  end

  assign dout = q.s2;
endmodule : pin_sync

/* axil_regport.sv */
// axi4-lite slave front end that turns bus beats into register strobes
`timescale 1ns/1ps
module axil_regport
  import i2c_target_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [i2c_target_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [i2c_target_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  output i2c_target_pkg::reg_wr_t          wr,
  output i2c_target_pkg::reg_rd_t          rd,
  input  wire logic [7:0]                  rd_data
);
  typedef struct packed {
    logic              awready, wready, bvalid, arready, rvalid, aw_have, w_have, wen;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0]        wdata;
  } port_t;

  port_t q, d;
  logic  ar_hit;
  logic  aw_hit;

  assign ar_hit = reg_hit(araddr);
  assign aw_hit = reg_hit(q.awaddr);

  always_comb begin
    d       = q;
    wr      = '0;
    rd      = '0;
    wr.idx  = q.awaddr[9:2];
    wr.data = q.wdata;
    if (awvalid && q.awready) begin
      d.awaddr  = awaddr;
      d.aw_have = 1'b1;
    end
    if (wvalid && q.wready) begin
      d.wdata  = wdata[7:0];
      d.wen    = wstrb[0];
      d.w_have = 1'b1;
    end
    if (q.bvalid && bready) d.bvalid = 1'b0;
    // commit only once both halves are held and the last answer is gone
    if (q.aw_have && q.w_have && !q.bvalid) begin
      wr.fire   = aw_hit && q.wen;
      d.bresp   = aw_hit ? RESP_OKAY : RESP_SLVERR;
      d.bvalid  = 1'b1;
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    if (q.rvalid && rready) d.rvalid = 1'b0;
    rd.idx = araddr[9:2];
    if (arvalid && q.arready) begin
      rd.fire = ar_hit;
      d.rdata = {24'h000000, ar_hit ? rd_data : 8'h00};
      d.rresp = ar_hit ? RESP_OKAY : RESP_SLVERR;
      d.rvalid = 1'b1;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else          q <= d;
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arready;
  assign rvalid  = q.rvalid;
  assign rresp   = q.rresp;
  assign rdata   = q.rdata;
endmodule : axil_regport

/* i2c_target.sv */
// i2c target port with its register file and bus protocol engine
// What this block does
// - soft-reset bit high holds the target logic in reset; low runs normally.
// - read-stretch bit high lets the target hold scl low on controller reads.
// - write-stretch bit high lets the target hold scl low on controller writes.
// - clock release bit low drives scl low while enabled and out of soft reset; high releases scl.
// - slew bit selects edge rate: one standard mode, zero fast mode.
// - enable bit high turns the target on; low, it ignores the bus.
// - own address sits in bits seven to one and is compared with addresses.
// - status bit seven shows a start condition was detected.
// - status bit six shows a stop was detected; reads one after reset.
// - status bit five holds the direction bit of the matched address; a start, a stop or a read nack clears it.
// - status bit four tells whether the last byte was data or address.
// - on receive, buffer-full is set when a byte waits in the data register.
// - on transmit, buffer-full stays high until the eight data bits are sent.
// - acknowledge status holds the sampled ninth bit: one means not acknowledged.
// - a data write during a transmission is refused and flags a collision.
// - a byte arriving over an unread one is dropped and flags overflow.
// - reading the data register clears buffer-full; software cannot touch it directly.
// - with stretching on, the ninth falling edge of an acknowledged byte clears release and raises the interrupt.
// - data writes are taken only in a read, read-stretch on, scl held.
`timescale 1ns/1ps
module i2c_target
  import i2c_target_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [i2c_target_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [i2c_target_pkg::ADDR_W-1:0] araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  input  wire logic                              scl_i,
  output logic                                   scl_o,
  output logic                                   scl_oe_n,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_n,
  output logic                                   edge_rate_std,
  output logic                                   port_interrupt
);
  import i2c_target_pkg::*;

  // ********************
  // state
  // ********************
  typedef struct packed {
    state_t     state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic       sda_low;
    logic [7:0] own_address;
    logic [7:0] data_shift_buffer;
    logic [7:0] port_configuration;
    logic [7:0] port_status;
    logic [7:0] transmit_receive_holding;
    logic [7:0] peripheral_pin_filter_select;
    logic       scl_prev, sda_prev, irq, scl_oe_n, sda_oe_n, drive_val;
  } core_t;

  localparam core_t CORE_RST = '{
    state: S_IDLE, bitcnt: 4'h0, shift: 8'h00, sda_low: 1'b0,
    own_address: OWN_RST, data_shift_buffer: DBUF_RST,
    port_configuration: CFG_RST, port_status: STAT_RST,
    transmit_receive_holding: HOLD_RST, peripheral_pin_filter_select: FILT_RST,
    scl_prev: 1'b1, sda_prev: 1'b1, irq: 1'b0, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
    drive_val: 1'b0};

  core_t      q, d;
  reg_wr_t    wr;
  reg_rd_t    rd;
  logic [7:0] rd_data;
  logic [1:0] pins_s;
  logic       scl_s, sda_s;
  logic       rise, fall, start_ev, stop_ev;
  logic       active, wr_dbuf, rd_dbuf, tx_open, addr_match;

  // ********************
  // submodules
  // ********************
  pin_sync #(.WIDTH(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({scl_i, sda_i}),
    .dout    (pins_s)
  );

  axil_regport u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr      (wr),
    .rd      (rd),
    .rd_data (rd_data)
  );

  // ********************
  // bus events
  // ********************
  assign scl_s    = pins_s[1];
  assign sda_s    = pins_s[0];
  assign rise     = scl_s && !q.scl_prev;
  assign fall     = !scl_s && q.scl_prev;
  assign start_ev = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_ev  = scl_s && q.scl_prev && !q.sda_prev && sda_s;
  assign active   = q.port_configuration[CFG_EN] && !q.port_configuration[CFG_SRST];
  assign wr_dbuf  = wr.fire && wr.idx == IDX_DBUF;
  assign rd_dbuf  = rd.fire && rd.idx == IDX_DBUF;
  // the only window in which software may load the data buffer with a byte to send
  assign tx_open  = q.port_status[ST_DIR] && q.port_configuration[CFG_RDS] &&
                    !q.port_configuration[CFG_REL];
  assign addr_match = q.shift[7:1] == q.own_address[7:1];

  always_comb begin
    unique case (rd.idx)
      IDX_OWN:  rd_data = q.own_address;
      IDX_DBUF: rd_data = q.data_shift_buffer;
      IDX_CFG:  rd_data = q.port_configuration;
      IDX_STAT: rd_data = q.port_status;
      IDX_HOLD: rd_data = q.transmit_receive_holding;
      IDX_FILT: rd_data = q.peripheral_pin_filter_select;
      default:  rd_data = 8'h00;
    endcase
  end

  // ********************
  // register file and protocol engine
  // ********************
  always_comb begin
    logic rx_load;
    rx_load    = 1'b0;
    d          = q;
    d.irq      = 1'b0;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    // software first, so that hardware sets below win over clears
    if (wr.fire) begin
      unique case (wr.idx)
        IDX_OWN:  d.own_address = wr.data;
        IDX_DBUF: begin
          if (tx_open) begin
            d.data_shift_buffer   = wr.data;
            d.port_status[ST_BF]  = 1'b1;
          end else begin
            d.port_status[ST_WCOL] = 1'b1;
          end
        end
        IDX_CFG:  d.port_configuration = wr.data & CFG_MASK;
        IDX_STAT: d.port_status[ST_WCOL:ST_ROVF] = wr.data[ST_WCOL:ST_ROVF];
        IDX_HOLD: d.transmit_receive_holding = wr.data;
        IDX_FILT: d.peripheral_pin_filter_select = wr.data & FILT_MASK;
        default:  d.own_address = q.own_address;
      endcase
    end
    if (rd_dbuf) d.port_status[ST_BF] = 1'b0;

    if (q.port_configuration[CFG_SRST]) begin
      d.state             = S_IDLE;
      d.bitcnt            = 4'h0;
      d.sda_low           = 1'b0;
      d.port_status       = STAT_RST;
      d.data_shift_buffer = DBUF_RST;
    end else if (!q.port_configuration[CFG_EN]) begin
      d.state   = S_IDLE;
      d.sda_low = 1'b0;
    end else if (start_ev) begin
      d.port_status[ST_START] = 1'b1;
      d.port_status[ST_STOP]  = 1'b0;
      d.port_status[ST_ACK]   = 1'b0;
      d.port_status[ST_DIR]   = 1'b0;
      d.state   = S_ADDR;
      // the scl fall that closes a start carries no bit, so it wraps the count to zero
      d.bitcnt  = 4'hF;
      d.sda_low = 1'b0;
    end else if (stop_ev) begin
      d.port_status[ST_STOP]  = 1'b1;
      d.port_status[ST_START] = 1'b0;
      d.port_status[ST_DIR]   = 1'b0;
      d.state   = S_IDLE;
      d.sda_low = 1'b0;
    end else begin
      unique case (q.state)
        S_IDLE: d.state = S_IDLE;
        S_ADDR, S_WDATA: begin
          if (rise) d.shift = {q.shift[6:0], sda_s};
          if (fall) begin
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == BIT_LAST) begin
              if (q.state == S_WDATA) begin
                d.port_status[ST_AD] = 1'b1;
                rx_load   = 1'b1;
                d.sda_low = 1'b1;
                d.state   = S_WACK;
              end else if (addr_match) begin
                d.port_status[ST_AD] = 1'b0;
                rx_load   = !q.shift[0];
                d.sda_low = 1'b1;
                d.state   = S_AACK;
              end else begin
                d.state = S_IDLE;
              end
            end
          end
        end
        S_AACK, S_WACK: begin
          if (rise) d.port_status[ST_ACK] = sda_s;
          if (fall) begin
            d.sda_low = 1'b0;
            d.irq     = 1'b1;
            d.bitcnt  = 4'h0;
            if (q.state == S_AACK) d.port_status[ST_DIR] = q.shift[0];
            if (q.state == S_AACK && q.shift[0]) begin
              d.state = S_RDATA;
              if (q.port_configuration[CFG_RDS]) begin
                d.port_configuration[CFG_REL] = 1'b0;
              end else begin
                d.data_shift_buffer  = q.transmit_receive_holding;
                d.port_status[ST_BF] = 1'b1;
              end
            end else begin
              d.state = S_WDATA;
              if (q.port_configuration[CFG_WRS]) begin
                d.port_configuration[CFG_REL] = 1'b0;
              end
            end
          end
        end
        S_RDATA: begin
          // bits change only while scl is low so no false start or stop
          if (!scl_s) d.sda_low = !d.data_shift_buffer[3'h7 - q.bitcnt[2:0]];
          if (fall) begin
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == BIT_LAST) begin
              d.port_status[ST_BF] = 1'b0;
              d.port_status[ST_AD] = 1'b1;
              d.sda_low = 1'b0;
              d.state   = S_RACK;
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            d.port_status[ST_ACK] = sda_s;
            if (sda_s) d.port_status[ST_DIR] = 1'b0;
          end
          if (fall) begin
            d.bitcnt = 4'h0;
            // a refusal ends the transfer without holding the clock
            if (q.port_status[ST_ACK]) begin
              d.state = S_IDLE;
            end else begin
              d.irq   = 1'b1;
              d.state = S_RDATA;
              if (q.port_configuration[CFG_RDS]) begin
                d.port_configuration[CFG_REL] = 1'b0;
              end else begin
                d.data_shift_buffer  = q.transmit_receive_holding;
                d.port_status[ST_BF] = 1'b1;
              end
            end
          end
        end
        default: d.state = S_IDLE;
      endcase
    end

    if (rx_load) begin
      if (d.port_status[ST_BF]) begin
        d.port_status[ST_ROVF] = 1'b1;
      end else begin
        d.data_shift_buffer  = q.shift;
        d.port_status[ST_BF] = 1'b1;
      end
    end

    d.scl_oe_n = !(d.port_configuration[CFG_EN] && !d.port_configuration[CFG_SRST] &&
                   !d.port_configuration[CFG_REL]);
    d.sda_oe_n = !d.sda_low;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= CORE_RST;
    else          q <= d;
  end

  assign scl_o          = q.drive_val;
  assign sda_o          = q.drive_val;
  assign scl_oe_n       = q.scl_oe_n;
  assign sda_oe_n       = q.sda_oe_n;
  assign edge_rate_std  = q.port_configuration[CFG_SLEW];
  assign port_interrupt = q.irq;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_ninth_fall_s;
    active && !start_ev && !stop_ev && q.state == S_WACK && fall;
  endsequence

  sequence read_ack_fall_s;
    active && !start_ev && !stop_ev && q.state == S_RACK && fall && !q.port_status[ST_ACK];
  endsequence

  soft_reset_hold_a: assert property (q.port_configuration[CFG_SRST]
    |=> q.state == S_IDLE && q.sda_oe_n && q.port_status[ST_STOP])
    else $error("soft reset did not hold the engine idle");

  read_stretch_a: assert property (read_ack_fall_s ##0 q.port_configuration[CFG_RDS]
    |=> !q.port_configuration[CFG_REL] && q.irq ##1 !scl_oe_n)
    else $error("read byte did not stretch the clock");

  write_stretch_a: assert property (write_ninth_fall_s
    |=> q.irq && (q.port_configuration[CFG_REL] == !$past(q.port_configuration[CFG_WRS])))
    else $error("write stretch did not follow its enable");

  release_drive_a: assert property (active && $fell(q.port_configuration[CFG_REL])
    && !q.port_configuration[CFG_SRST] |-> !scl_oe_n)
    else $error("scl not driven after release was cleared");

  disabled_quiet_a: assert property (!q.port_configuration[CFG_EN]
    |=> sda_oe_n && !q.irq)
    else $error("disabled target touched the bus");

  start_flag_a: assert property (active && start_ev
    |=> q.port_status[ST_START] && !q.port_status[ST_STOP] && q.state == S_ADDR)
    else $error("start condition not recorded");

  stop_flag_a: assert property (active && stop_ev
    |=> q.port_status[ST_STOP] && !q.port_status[ST_START] && q.state == S_IDLE)
    else $error("stop condition not recorded");

  collision_a: assert property (wr_dbuf && !tx_open
    |=> q.port_status[ST_WCOL] && $stable(q.data_shift_buffer))
    else $error("refused data write not flagged");

  overflow_a: assert property (active && !start_ev && !stop_ev && q.state == S_WDATA
    && fall && q.bitcnt == BIT_LAST && q.port_status[ST_BF] && !rd_dbuf
    |=> q.port_status[ST_ROVF] && $stable(q.data_shift_buffer))
    else $error("overflowing byte overwrote the buffer");

  addr_miss_a: assert property (active && !start_ev && !stop_ev && q.state == S_ADDR
    && fall && q.bitcnt == BIT_LAST && !addr_match
    |=> q.state == S_IDLE ##1 sda_oe_n)
    else $error("foreign address was answered");
endmodule : i2c_target

/* ctrl_model.sv */
// controller-side model of the two-wire bus; lines are released high
`timescale 1ns/1ps
module ctrl_model (
  output logic     scl_m,
  output logic     sda_m,
  input wire logic scl_w,
  input wire logic sda_w
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start_c;
    #100 sda_m = 1'b0;
    #100 scl_m = 1'b0;
  endtask : start_c
  // a target holding scl low stretches the bit; msb first, ninth bit last
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #50 sda_m = tx[i];
      #50 scl_m = 1'b1;
      wait (scl_w) #100 rx[i] = sda_w;
      scl_m = 1'b0;
    end
    #50 sda_m = 1'b1;
    #400;
  endtask : xfer
  task automatic stop_c;
    #50 sda_m = 1'b0;
    #50 scl_m = 1'b1;
    wait (scl_w) #100 sda_m = 1'b1;
    #200;
  endtask : stop_c
endmodule : ctrl_model

/* i2c_target_bench.sv */
// self-checking bench of the i2c target register block
`timescale 1ns/1ps
module i2c_target_bench;
  import i2c_target_pkg::*;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, edge_rate_std, port_interrupt, scl_m, sda_m;
  logic [8:0]  rx;
  int          fails = 0, compares = 0, irqs = 0;
  wire         scl_w = scl_m & (scl_oe_n | scl_o);
  wire         sda_w = sda_m & (sda_oe_n | sda_o);
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (port_interrupt === 1'b1) irqs++;
  i2c_target u_i2c_target (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n,
    .edge_rate_std, .port_interrupt);
  ctrl_model u_ctrl_model (.scl_m, .sda_m, .scl_w, .sda_w);
  // ********************
  // tasks
  // ********************
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk("bresp", 10'h0, {8'h0, bresp});
        break;
      end
    end
  endtask : wr
  task automatic rchk(input logic [7:0] i, input logic [9:0] e);
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk($sformatf("reg %h", i), e, {rresp, rdata[7:0]});
        break;
      end
    end
  endtask : rchk
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // ********************
  // scenarios
  // ********************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk("rate", 10'h0, {9'h0, edge_rate_std});
    rchk(IDX_OWN, 10'h000);
    rchk(IDX_DBUF, 10'h000);
    rchk(IDX_CFG, 10'h010);
    rchk(IDX_STAT, 10'h044);
    rchk(IDX_HOLD, 10'h000);
    rchk(IDX_FILT, 10'h040);
    rchk(8'h00, 10'h200);
    wr(IDX_OWN, 8'hA4);
    u_ctrl_model.start_c();
    u_ctrl_model.xfer(9'h149, rx);
    chk("ack", 10'h1, {9'h0, rx[0]});
    u_ctrl_model.stop_c();
    rchk(IDX_STAT, 10'h044);
    wr(IDX_CFG, 8'h1F);
    chk("rate", 10'h1, {9'h0, edge_rate_std});
    u_ctrl_model.start_c();
    rchk(IDX_STAT, 10'h080);
    u_ctrl_model.xfer(9'h149, rx);
    chk("ack", 10'h0, {9'h0, rx[0]});
    chk("hold", 10'h0, {9'h0, scl_oe_n});
    rchk(IDX_STAT, 10'h088);
    rchk(IDX_DBUF, 10'h0A4);
    wr(IDX_CFG, 8'h1F);
    u_ctrl_model.xfer(9'h0B5, rx);
    rchk(IDX_STAT, 10'h098);
    wr(IDX_CFG, 8'h1F);
    u_ctrl_model.xfer(9'h067, rx);
    rchk(IDX_STAT, 10'h099);
    wr(IDX_STAT, 8'h00);
    rchk(IDX_STAT, 10'h098);
    rchk(IDX_DBUF, 10'h05A);
    rchk(IDX_STAT, 10'h090);
    wr(IDX_CFG, 8'h1F);
    repeat (4) @(posedge aclk);
    chk("hold", 10'h1, {9'h0, scl_oe_n});
    u_ctrl_model.stop_c();
    rchk(IDX_STAT, 10'h050);
    u_ctrl_model.start_c();
    u_ctrl_model.xfer(9'h16D, rx);
    chk("ack", 10'h1, {9'h0, rx[0]});
    chk("hold", 10'h1, {9'h0, scl_oe_n});
    u_ctrl_model.stop_c();
    rchk(IDX_STAT, 10'h050);
    wr(IDX_DBUF, 8'h11);
    rchk(IDX_STAT, 10'h052);
    rchk(IDX_DBUF, 10'h05A);
    wr(IDX_STAT, 8'h00);
    u_ctrl_model.start_c();
    u_ctrl_model.xfer(9'h14B, rx);
    rchk(IDX_STAT, 10'h0A0);
    wr(IDX_DBUF, 8'hC3);
    rchk(IDX_STAT, 10'h0A8);
    wr(IDX_CFG, 8'h1F);
    u_ctrl_model.xfer(9'h1FE, rx);
    chk("rx", 10'h186, {1'b0, rx});
    chk("hold", 10'h0, {9'h0, scl_oe_n});
    rchk(IDX_STAT, 10'h0B0);
    wr(IDX_DBUF, 8'h3C);
    wr(IDX_CFG, 8'h1F);
    u_ctrl_model.xfer(9'h1FF, rx);
    chk("rx", 10'h079, {1'b0, rx});
    rchk(IDX_STAT, 10'h094);
    chk("irq", 10'h5, irqs[9:0]);
    u_ctrl_model.stop_c();
    wr(IDX_CFG, 8'h3F);
    rchk(IDX_STAT, 10'h044);
    wr(IDX_HOLD, 8'h96);
    wr(IDX_CFG, 8'h07);
    u_ctrl_model.start_c();
    u_ctrl_model.xfer(9'h14B, rx);
    chk("hold", 10'h1, {9'h0, scl_oe_n});
    u_ctrl_model.xfer(9'h1FF, rx);
    chk("rx", 10'h12D, {1'b0, rx});
    u_ctrl_model.stop_c();
    give_verdict();
  end
  // the run needs about 30 us; this cuts a stuck handshake or bus short
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule : i2c_target_bench
